// [src/usr_params.svh]
// Offsets, field positions, reset values and timing counts of the serial receiver block.
`ifndef USR_PARAMS_SVH
`define USR_PARAMS_SVH
`define USR_OFF_RX_STAT_CTRL 8'h13
`define USR_OFF_TX_STAT_CTRL 8'h15
`define USR_OFF_TX_HOLD 8'h16
`define USR_OFF_BAUD_DIV 8'h17
`define USR_OFF_INT_FLAGS 8'h26
`define USR_OFF_INT_ENABLES 8'h27
`define USR_RX_PORT_EN 7
`define USR_RX_NINTH_SEL 6
`define USR_RX_SINGLE_EN 5
`define USR_RX_CONT_EN 4
`define USR_RX_FRAME_ERR 2
`define USR_RX_OVERRUN 1
`define USR_RX_NINTH_BIT 0
`define USR_TX_CLK_SRC 7
`define USR_TX_NINTH_SEL 6
`define USR_TX_EN 5
`define USR_TX_SYNC 4
`define USR_TX_SHIFT_EMPTY 1
`define USR_TX_NINTH_BIT 0
`define USR_INT_RX 0
`define USR_INT_TX 1
`define USR_INT_FLAGS_RST 8'h02
`define USR_INT_ENABLES_RST 8'h00
`define USR_OVERSAMPLE 16
`define USR_SAMPLE_A 4'h6
`define USR_SAMPLE_B 4'h7
`define USR_SAMPLE_C 4'h8
`define USR_FIFO_DEPTH 8
`endif

// [src/usr_pkg.sv]
// Types shared by the serial receiver block.
package usr_pkg;
    // One received word with its status, as queued in the receive buffer.
    typedef struct packed {
        logic frame_err;
        logic ninth;
        logic [7:0] data;
    } usr_word_t;

    // Receive state machine.
    typedef enum logic [1:0] {
        USR_IDLE = 2'b00,
        USR_START = 2'b01,
        USR_DATA = 2'b10,
        USR_STOP = 2'b11
    } usr_rx_state_t;
endpackage : usr_pkg

// [src/usr_fifo.sv]
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module usr_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Synchronous flush
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [$clog2(DEPTH+1)-1:0] count;
    logic push;
    logic pop;

    // Handshakes; a full buffer refuses the source.
    assign in_ready = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign level = count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage written at the write pointer.
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else if (flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : usr_fifo
`default_nettype wire

// [src/usr_receiver.sv]
// Asynchronous serial receiver with register port, pin direction control and receive buffer.
// Operation
// [RULE_01] Port enable must be set before the shared pins serve the serial block.
// [RULE_02] Block itself drives data and clock pin direction from its configuration bits.
// [RULE_03] Synchronous mode: clock source set means master, clear means slave clock.
// [RULE_04] Recovery runs at sixteen times baud; shifter advances once per bit.
// [RULE_05] Asynchronous reception starts only once continuous receive enable is set.
// [RULE_06] After stop bit, word moves to buffer if room; move sets receive flag.
// [RULE_07] Receive interrupt request reaches the processor only while enabled.
// [RULE_08] Receive flag is read-only; clears when reads empty the buffer.
// [RULE_09] Buffer holds two words; third may shift in; reads return arrival order.
// [RULE_10] Buffer full at third stop bit sets overrun and drops the word.
// [RULE_11] Overrun clears only by dropping continuous receive enable; writes ignored.
// [RULE_12] While overrun is set, no word moves into the buffer.
// [RULE_13] Framing error is set when the stop bit samples low.
// [RULE_14] Framing error and ninth bit travel with each word; reads advance them.
// [RULE_15] Software reads status before data, else current word status is lost.
// [RULE_16] Each bit is a majority of samples seven, eight and nine.
// [RULE_17] The sixteen-times clock runs freely and is never restarted by data.
// [RULE_18] Frame: low start, eight or nine data bits LSB first, high stop.
// [RULE_19] Start bit is found on a falling edge of the idle-high line.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "usr_params.svh"
module usr_receiver #(
    parameter int FIFO_DEPTH = `USR_FIFO_DEPTH,
    parameter int HOLD_WORDS = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Receive data pin (two-way)
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe,
    // Clock pin (two-way)
    input wire logic clock_pin_in,
    output logic clock_pin_out,
    output logic clock_pin_oe,
    // Processor interrupt request
    output logic rx_irq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int LW = $clog2(FIFO_DEPTH + 1);
    logic [7:0] rx_ctrl;
    logic [7:0] tx_ctrl;
    logic [7:0] baud_divisor;
    logic [7:0] int_enables;
    logic overrun_error;
    logic [7:0] baud_cnt;
    logic tick16;
    logic [3:0] phase16;
    logic [1:0] data_sync;
    logic [1:0] clk_sync;
    logic line_q;
    logic [2:0] votes;
    logic bit_value;
    logic sample_done;
    usr_pkg::usr_rx_state_t state;
    logic [3:0] bit_cnt;
    logic [8:0] receive_shifter;
    logic push_valid;
    logic push_ready;
    usr_pkg::usr_word_t push_word;
    logic pop_valid;
    logic pop;
    usr_pkg::usr_word_t head;
    logic [LW-1:0] level;
    logic rx_on;
    logic serial_port_enable;
    logic read_fifo;
    logic [3:0] last_bit;
    logic rx_flag;
    logic start_edge;

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    // [RULE_01] port enable
    assign serial_port_enable = rx_ctrl[`USR_RX_PORT_EN];
    // [RULE_05] reception gated by enable
    assign rx_on = serial_port_enable && rx_ctrl[`USR_RX_CONT_EN] && !tx_ctrl[`USR_TX_SYNC];
    assign last_bit = rx_ctrl[`USR_RX_NINTH_SEL] ? 4'h9 : 4'h8;
    assign read_fifo = reg_rd && (reg_addr == `USR_OFF_TX_HOLD);
    assign rx_flag = pop_valid;
    // [RULE_19] start edge while idle
    assign start_edge = rx_on && (state == usr_pkg::USR_IDLE) && line_q && !data_sync[1];

    // ----------------------------------------------------------------
    // Pin direction
    // ----------------------------------------------------------------
    // [RULE_02] pin direction ownership
    // Async: data pin is an input, clock pin carries idle-high transmit line when enabled.
    // Sync: data pin drives while transmitting, clock pin drives only as master.
    always_comb
    begin
        data_pin_oe = 1'b0;
        clock_pin_oe = 1'b0;
        if (serial_port_enable)
        begin
            if (tx_ctrl[`USR_TX_SYNC])
            begin
                data_pin_oe = tx_ctrl[`USR_TX_EN] && !rx_ctrl[`USR_RX_CONT_EN]
                              && !rx_ctrl[`USR_RX_SINGLE_EN];
                // [RULE_03] master drives clock
                clock_pin_oe = tx_ctrl[`USR_TX_CLK_SRC];
            end
            else
            begin
                clock_pin_oe = tx_ctrl[`USR_TX_EN];
            end
        end
    end
    assign data_pin_out = 1'b1; // Transmitter is outside this block; line idles high.
    assign clock_pin_out = tx_ctrl[`USR_TX_SYNC] ? tick16 : 1'b1;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two flip-flops on each pin before any logic reads it.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            data_sync <= 2'b11;
            clk_sync <= 2'b11;
        end
        else
        begin
            data_sync <= {data_sync[0], data_pin_in};
            clk_sync <= {clk_sync[0], clock_pin_in};
        end
    end

    // ----------------------------------------------------------------
    // Sixteen-times clock
    // ----------------------------------------------------------------
    // [RULE_17] free-running divider
    // The divider runs from reset on and is never restarted, so the
    // sample points recur every sixteen ticks.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            baud_cnt <= 8'h00;
            tick16 <= 1'b0;
        end
        else if (baud_cnt >= baud_divisor)
        begin
            baud_cnt <= 8'h00;
            tick16 <= 1'b1;
        end
        else
        begin
            baud_cnt <= baud_cnt + 8'h01;
            tick16 <= 1'b0;
        end
    end

    // [RULE_04] oversample phase count
    // [RULE_19] aligned at start
    // A start edge lines the tick count up with the frame, so the three samples
    // sit in the middle of every bit; the ticks themselves keep running.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase16 <= 4'h0;
        end
        else if (start_edge)
        begin
            phase16 <= 4'h0;
        end
        else if (tick16)
        begin
            phase16 <= phase16 + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Majority sampling
    // ----------------------------------------------------------------
    // [RULE_16] three samples per bit
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            votes <= 3'b111;
            sample_done <= 1'b0;
        end
        else
        begin
            sample_done <= 1'b0;
            // A tick in the start edge cycle belongs to the old count and is skipped.
            if (tick16 && !start_edge)
            begin
                if (phase16 == `USR_SAMPLE_A)
                begin
                    votes[0] <= data_sync[1];
                end
                if (phase16 == `USR_SAMPLE_B)
                begin
                    votes[1] <= data_sync[1];
                end
                if (phase16 == `USR_SAMPLE_C)
                begin
                    votes[2] <= data_sync[1];
                    sample_done <= 1'b1;
                end
            end
        end
    end
    // [RULE_16] majority vote
    assign bit_value = (votes[0] & votes[1]) | (votes[1] & votes[2]) | (votes[0] & votes[2]);

    // Previous line level for the start edge detector.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            line_q <= 1'b1;
        end
        else
        begin
            line_q <= data_sync[1];
        end
    end

    // ----------------------------------------------------------------
    // Receive state machine
    // ----------------------------------------------------------------
    // [RULE_18] frame layout
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= usr_pkg::USR_IDLE;
            bit_cnt <= 4'h0;
            receive_shifter <= 9'h000;
            push_valid <= 1'b0;
            push_word <= '0;
        end
        else
        begin
            push_valid <= 1'b0;
            if (!rx_on)
            begin
                state <= usr_pkg::USR_IDLE;
            end
            else
            begin
                case (state)
                    usr_pkg::USR_IDLE:
                    begin
                        // [RULE_19] falling edge starts frame
                        if (start_edge)
                        begin
                            state <= usr_pkg::USR_START;
                        end
                    end
                    usr_pkg::USR_START:
                    begin
                        if (sample_done)
                        begin
                            // A high start sample is a glitch; go back to idle.
                            state <= bit_value ? usr_pkg::USR_IDLE : usr_pkg::USR_DATA;
                            bit_cnt <= 4'h0;
                        end
                    end
                    usr_pkg::USR_DATA:
                    begin
                        // [RULE_04] one shift per bit
                        if (sample_done)
                        begin
                            receive_shifter <= {bit_value, receive_shifter[8:1]};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt + 4'h1 == last_bit)
                            begin
                                state <= usr_pkg::USR_STOP;
                            end
                        end
                    end
                    usr_pkg::USR_STOP:
                    begin
                        if (sample_done)
                        begin
                            state <= usr_pkg::USR_IDLE;
                            // [RULE_12] no move while overrun
                            // [RULE_10] full buffer drops word
                            push_valid <= !overrun_error && push_ready;
                            // [RULE_13] stop sampled low
                            push_word.frame_err <= !bit_value;
                            push_word.ninth <= rx_ctrl[`USR_RX_NINTH_SEL] ? receive_shifter[8]
                                                                       : 1'b0;
                            push_word.data <= rx_ctrl[`USR_RX_NINTH_SEL] ? receive_shifter[7:0]
                                                                      : receive_shifter[8:1];
                        end
                    end
                    default:
                    begin
                        state <= usr_pkg::USR_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Overrun
    // ----------------------------------------------------------------
    // [RULE_10] set on full buffer
    // [RULE_11] cleared only by receive enable low
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            overrun_error <= 1'b0;
        end
        else if (rx_on && state == usr_pkg::USR_STOP && sample_done && !push_ready)
        begin
            overrun_error <= 1'b1;
        end
        else if (!rx_ctrl[`USR_RX_CONT_EN])
        begin
            overrun_error <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Receive buffer
    // ----------------------------------------------------------------
    // [RULE_09] two-word hold limit
    assign push_ready = (level < LW'(HOLD_WORDS));
    assign pop = read_fifo && pop_valid;

    // [RULE_14] status queued with data
    usr_fifo #(
        .WIDTH($bits(usr_pkg::usr_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .flush(!serial_port_enable),
        .in_valid(push_valid),
        .in_ready(),
        .in_data(push_word),
        .out_valid(pop_valid),
        .out_ready(pop),
        .out_data(head),
        .level(level)
    );

    // [RULE_07] gated interrupt
    assign rx_irq = rx_flag && int_enables[`USR_INT_RX];

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // [RULE_08] flag and status bits not writable
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_ctrl <= 8'h00;
            tx_ctrl <= 8'h00;
            baud_divisor <= 8'h00;
            int_enables <= `USR_INT_ENABLES_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `USR_OFF_RX_STAT_CTRL)
            begin
                rx_ctrl <= {reg_wdata[7:4], 4'h0};
            end
            else if (reg_addr == `USR_OFF_TX_STAT_CTRL)
            begin
                tx_ctrl <= {reg_wdata[7:4], 3'b000, reg_wdata[0]};
            end
            else if (reg_addr == `USR_OFF_BAUD_DIV)
            begin
                baud_divisor <= reg_wdata;
            end
            else if (reg_addr == `USR_OFF_INT_ENABLES)
            begin
                int_enables <= reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    // [RULE_15] status shows head word until read
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (reg_addr == `USR_OFF_RX_STAT_CTRL)
            begin
                reg_rdata <= {rx_ctrl[7:4], 1'b0, head.frame_err && pop_valid,
                              overrun_error, head.ninth && pop_valid};
            end
            else if (reg_addr == `USR_OFF_TX_STAT_CTRL)
            begin
                reg_rdata <= {tx_ctrl[7:4], 2'b00, 1'b1, tx_ctrl[0]};
            end
            else if (reg_addr == `USR_OFF_TX_HOLD)
            begin
                reg_rdata <= pop_valid ? head.data : 8'h00;
            end
            else if (reg_addr == `USR_OFF_BAUD_DIV)
            begin
                reg_rdata <= baud_divisor;
            end
            else if (reg_addr == `USR_OFF_INT_FLAGS)
            begin
                // [RULE_06] receive flag
                reg_rdata <= {6'h00, 1'b1, rx_flag};
            end
            else if (reg_addr == `USR_OFF_INT_ENABLES)
            begin
                reg_rdata <= int_enables;
            end
            else
            begin
                reg_rdata <= 8'h00;
            end
        end
    end
endmodule : usr_receiver
`default_nettype wire

// [tb/usr_assertions.sv]
// Port checker for the serial receiver, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module usr_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pin directions and interrupt
    input wire logic data_pin_oe,
    input wire logic clock_pin_oe,
    input wire logic rx_irq
);
    logic ie;
    logic [3:0] ctrl;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Mirror of the interrupt enable and the upper control bits as software wrote them.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ie <= 1'b0;
            ctrl <= 4'h0;
        end
        else if (reg_wr && reg_addr == 8'h27)
            ie <= reg_wdata[0];
        else if (reg_wr && reg_addr == 8'h13)
            ctrl <= reg_wdata[7:4];
    end
    a_pins_released: assert property (!ctrl[3] && !$past(ctrl[3]) |-> !data_pin_oe && !clock_pin_oe)
        else $error("pin driven while the port is off");
    a_irq_gated: assert property (rx_irq |-> ie)
        else $error("interrupt request while masked");
    a_flag_is_irq: assert property (reg_rd && reg_addr == 8'h26 && ie |=> reg_rdata[0] == $past(rx_irq))
        else $error("receive flag disagrees with request");
    a_flag_drop_pop: assert property ($fell(rx_irq) |-> !ie || !ctrl[3]
        || $past(reg_rd && reg_addr == 8'h16) || $past(reg_rd && reg_addr == 8'h16, 2))
        else $error("receive flag fell without a read");
    a_ctrl_readback: assert property (reg_rd && reg_addr == 8'h13 |=> reg_rdata[7:3] == {$past(ctrl), 1'b0})
        else $error("control bits read back wrong");
    a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_tx_status: assert property (reg_rd && reg_addr == 8'h15 |=> reg_rdata[3:1] == 3'b001)
        else $error("transmit status bits wrong");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    // Main scenarios reached.
    c_irq: cover property ($rose(rx_irq));
    c_overrun: cover property (reg_rd && reg_addr == 8'h13 ##1 reg_rdata[1]);
    c_frame_err: cover property (reg_rd && reg_addr == 8'h13 ##1 reg_rdata[2]);
endmodule : usr_assertions
bind usr_receiver usr_assertions u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .data_pin_oe(data_pin_oe), .clock_pin_oe(clock_pin_oe),
    .rx_irq(rx_irq));
`default_nettype wire

// [tb/usr_line_model.sv]
// Remote serial terminal that sends asynchronous frames on the receive line.
`timescale 1ns/1ps
`default_nettype none
module usr_line_model #(
    parameter int BIT_NS = 128
) (
    // Serial line towards the receiver
    output logic line
);
    initial line = 1'b1;
    // Frame on wire
    // Start low, data least significant bit first, stop, then idle high.
    task automatic send(input logic [8:0] word, input bit nine, input bit stop);
        #1; // Launch off the clock edge so the pin never races the sampling flop.
        line = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < (nine ? 9 : 8); i++)
        begin
            line = word[i];
            #(BIT_NS);
        end
        line = stop;
        #(BIT_NS);
        line = 1'b1;
        #(2 * BIT_NS);
    endtask : send
endmodule : usr_line_model
`default_nettype wire

// [tb/usr_receiver_test.sv]
// Self-checking bench for the serial receiver.
`timescale 1ns/1ps
`default_nettype none
module usr_receiver_test;
    logic core_clk;
    logic sys_rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic line;
    logic rx_irq;
    logic clk_oe;
    int num_errors;
    int checks;
    logic [9:0] exp_q[$];
    usr_line_model #(.BIT_NS(128)) u_term (.line(line));
    usr_receiver DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .data_pin_in(line), .data_pin_out(), .data_pin_oe(), .clock_pin_in(1'b1),
        .clock_pin_out(), .clock_pin_oe(clk_oe), .rx_irq(rx_irq));
    // Compares one value and counts it.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // One-cycle register read; data taken in the following cycle.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : rd
    // Sends a frame and queues the word when it should be kept.
    task automatic frame(input logic [8:0] w, input bit nine, input bit stop, input bit keep);
        u_term.send(w, nine, stop);
        repeat (40) @(posedge core_clk);
        if (keep)
            exp_q.push_back({~stop, nine & w[8], w[7:0]});
    endtask : frame
    // Status before data
    // Takes the head word and compares it with the model queue.
    task automatic take();
        logic [7:0] s;
        logic [7:0] d;
        logic [9:0] e;
        e = exp_q.pop_front();
        rd(8'h13, s);
        rd(8'h16, d);
        chk(s & 8'h05, {5'h0, e[9], 1'b0, e[8]});
        chk(d, e[7:0]);
    endtask : take
    // Prints the verdict and ends the run.
    task automatic final_report();
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    // Free-running 250 MHz clock.
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Watchdog against a hung run.
    initial
    begin
        #200000;
        num_errors++;
        final_report();
    end
    // Main sequence.
    initial
    begin
        logic [7:0] v;
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        num_errors = 0;
        checks = 0;
        void'($urandom(55));
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(8'h26, v);
        chk(v, 8'h02);
        rd(8'h27, v);
        chk(v, 8'h00);
        rd(8'h40, v);
        chk(v, 8'h00);
        rd(8'h15, v);
        chk(v & 8'h0E, 8'h02);
        wr(8'h17, 8'h01);
        wr(8'h13, 8'h80);
        frame(9'h0A5, 0, 1, 0);
        rd(8'h26, v);
        chk(v & 8'h01, 8'h00);
        wr(8'h27, 8'h01);
        wr(8'h13, 8'h90);
        repeat (2) frame(9'($urandom) & 9'h0FF, 0, 1, 1);
        chk({7'h0, rx_irq}, 8'h01);
        wr(8'h27, 8'h00);
        @(negedge core_clk);
        chk({7'h0, rx_irq}, 8'h00);
        wr(8'h26, 8'h00);
        rd(8'h26, v);
        chk(v & 8'h01, 8'h01);
        take();
        take();
        rd(8'h26, v);
        chk(v & 8'h01, 8'h00);
        wr(8'h27, 8'h01);
        // Both widths, with good and bad stop bits.
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h13, m[1] ? 8'hD0 : 8'h90);
            frame(9'($urandom), m[1], m[0], 1);
            take();
        end
        wr(8'h13, 8'h90);
        for (int i = 0; i < 4; i++)
            frame(9'($urandom) & 9'h0FF, 0, 1, i < 2);
        rd(8'h13, v);
        chk(v & 8'h02, 8'h02);
        wr(8'h13, 8'h90);
        rd(8'h13, v);
        chk(v & 8'h02, 8'h02);
        take();
        take();
        frame(9'($urandom) & 9'h0FF, 0, 1, 0);
        rd(8'h26, v);
        chk(v & 8'h01, 8'h00);
        wr(8'h13, 8'h80);
        wr(8'h13, 8'h90);
        rd(8'h13, v);
        chk(v & 8'h02, 8'h00);
        frame(9'($urandom) & 9'h0FF, 0, 1, 1);
        take();
        // Synchronous master drives the clock pin, slave leaves it.
        wr(8'h15, 8'h90);
        @(negedge core_clk);
        chk({7'h0, clk_oe}, 8'h01);
        wr(8'h15, 8'h10);
        @(negedge core_clk);
        chk({7'h0, clk_oe}, 8'h00);
        final_report();
    end
endmodule : usr_receiver_test
`default_nettype wire
